// File: core/ltsd_top.sv
`default_nettype none
module ltsd_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [ltsd_pkg::ADDR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic cold_event_i,
  input wire logic [ltsd_pkg::DAY_W-1:0] cal_day_i,
  input wire logic [ltsd_pkg::MONTH_W-1:0] cal_month_i
);
  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic enable;
    logic last_sel;
    logic clear;
  } ltsd_state_t;

  ltsd_state_t s_q;
  ltsd_state_t s_d;
  logic [ltsd_pkg::DAY_W-1:0] day_stamp;
  logic [ltsd_pkg::MONTH_W-1:0] month_stamp;
  logic day_taken;
  logic req;
  logic [31:0] ctrl_word;

  // =====================================================
  // Capture slices
  ltsd_capture #(.W(ltsd_pkg::DAY_W)) u_day (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .event_i(cold_event_i),
    .enable_i(s_q.enable),
    .last_sel_i(s_q.last_sel),
    .clear_i(s_q.clear),
    .value_i(cal_day_i),
    .stamp_o(day_stamp),
    .taken_o(day_taken)
  );

  ltsd_capture #(.W(ltsd_pkg::MONTH_W)) u_month (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .event_i(cold_event_i),
    .enable_i(s_q.enable),
    .last_sel_i(s_q.last_sel),
    .clear_i(s_q.clear),
    .value_i(cal_month_i),
    .stamp_o(month_stamp),
    .taken_o()
  );

  // =====================================================
  // Wishbone slave
  assign req = cyc_i && stb_i && !s_q.ack;

  always_comb begin
    ctrl_word = '0;
    ctrl_word[ltsd_pkg::CTRL_EN_BIT] = s_q.enable;
    ctrl_word[ltsd_pkg::CTRL_LAST_BIT] = s_q.last_sel;
    ctrl_word[ltsd_pkg::CTRL_DONE_BIT] = day_taken;
  end

  always_comb begin
    s_d = s_q;
    s_d.ack = req;
    s_d.clear = 1'b0;
    if (req && !we_i) begin
      case (adr_i)
        ltsd_pkg::ADDR_DAY: s_d.rdata = {26'h0, day_stamp};
        ltsd_pkg::ADDR_MONTH: s_d.rdata = {27'h0, month_stamp};
        ltsd_pkg::ADDR_CTRL: s_d.rdata = ctrl_word;
        default: s_d.rdata = ltsd_pkg::UNMAPPED_DATA;
      endcase
    end
    // Stamp addresses ignore write data; the write is still acked
    if (req && we_i && adr_i == ltsd_pkg::ADDR_CTRL && sel_i[0]) begin
      s_d.enable = dat_i[ltsd_pkg::CTRL_EN_BIT];
      s_d.last_sel = dat_i[ltsd_pkg::CTRL_LAST_BIT];
      s_d.clear = dat_i[ltsd_pkg::CTRL_CLR_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign ack_o = s_q.ack;
  assign dat_o = s_q.rdata;
endmodule
`default_nettype wire

// File: core/ltsd_pkg.sv
`default_nettype none
package ltsd_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_DAY = 8'h1c;
  localparam logic [7:0] IDX_MONTH = 8'h1d;
  localparam logic [7:0] IDX_CTRL = 8'h20;
  localparam int ADDR_W = 10;
  localparam logic [ADDR_W-1:0] ADDR_DAY = {IDX_DAY, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_MONTH = {IDX_MONTH, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_CTRL = {IDX_CTRL, 2'b00};
  // Control register bits
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_LAST_BIT = 1;
  localparam int CTRL_CLR_BIT = 2;
  localparam int CTRL_DONE_BIT = 3;
  // Field widths, stamp reset value and unmapped read data
  localparam int DAY_W = 6;
  localparam int MONTH_W = 5;
  localparam logic [7:0] STAMP_RST = 8'h00;
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
endpackage
`default_nettype wire

// File: core/ltsd_capture.sv
`default_nettype none
// Holds one stamped calendar field with first/last selection
module ltsd_capture #(
  parameter int W = 6
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic event_i,
  input wire logic enable_i,
  input wire logic last_sel_i,
  input wire logic clear_i,
  input wire logic [W-1:0] value_i,
  output logic [W-1:0] stamp_o,
  output logic taken_o
);
  typedef struct packed {
    logic [W-1:0] stamp;
    logic taken;
  } ltsd_cap_t;

  ltsd_cap_t s_q;
  ltsd_cap_t s_d;

  always_comb begin
    s_d = s_q;
    if (clear_i) begin
      s_d.stamp = '0;
      s_d.taken = 1'b0;
    end else if (event_i && enable_i && (last_sel_i || !s_q.taken)) begin
      s_d.stamp = value_i;
      s_d.taken = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign stamp_o = s_q.stamp;
  assign taken_o = s_q.taken;
endmodule
`default_nettype wire

// File: test/ltsd_sva.sv
`default_nettype none
module ltsd_sva (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [ltsd_pkg::ADDR_W-1:0] adr_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack;
    cyc_i && stb_i && we_i && !ack_o |=> ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("write not acked");
  property p_day;
    ack_o && $past(adr_i) == ltsd_pkg::ADDR_DAY && !$past(we_i) |-> dat_o[31:6] == '0;
  endproperty
  a_day: assert property (p_day) else $error("day upper bits set");
  property p_mon;
    ack_o && $past(adr_i) == ltsd_pkg::ADDR_MONTH && !$past(we_i) |-> dat_o[31:5] == '0;
  endproperty
  a_mon: assert property (p_mon) else $error("month upper bits set");
  property p_rst;
    disable iff (1'b0) $fell(rst_i) |-> dat_o == '0 && !ack_o;
  endproperty
  a_rst: assert property (p_rst) else $error("not clear after reset");
  property p_pulse;
    ack_o |=> !ack_o;
  endproperty
  a_pulse: assert property (p_pulse) else $error("ack longer than one cycle");
endmodule
bind ltsd_top ltsd_sva i_sva (.*);
`default_nettype wire

// File: test/testbench.sv
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, cold_event_i = 0, ack_o;
  logic [ltsd_pkg::ADDR_W-1:0] adr_i = '0;
  logic [3:0] sel_i = 4'hf;
  logic [31:0] dat_i = '0, dat_o, rd;
  logic [5:0] cal_day_i = '0;
  logic [4:0] cal_month_i = '0;
  int err_count = 0, num_checks = 0, cyc_n = 0;
  localparam logic [9:0] D = ltsd_pkg::ADDR_DAY, M = ltsd_pkg::ADDR_MONTH;
  ltsd_top i_dut (.*);
  initial forever #50 clk_i = ~clk_i;
  task close_out;
    if (err_count == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 3000) begin
      err_count++;
      close_out();
    end
  end
  task wb(input logic w, input logic [9:0] a, input logic [31:0] d);
    cyc_i <= 1;
    stb_i <= 1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 0;
    stb_i <= 0;
    @(posedge clk_i);
  endtask
  task chk(input logic [9:0] a, input logic [7:0] e);
    wb(0, a, 32'h0);
    num_checks++;
    if (rd !== {24'h0, e}) begin
      err_count++;
      $display("ERROR adr %h exp %h got %h", a, e, rd);
    end
  endtask
  task ev(input logic [5:0] d, input logic [4:0] m);
    cal_day_i <= d;
    cal_month_i <= m;
    cold_event_i <= 1;
    @(posedge clk_i);
    cold_event_i <= 0;
    @(posedge clk_i);
  endtask
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 0;
    chk(D, 8'h00);
    chk(M, 8'h00);
    wb(1, ltsd_pkg::ADDR_CTRL, 32'h1);
    ev(6'h31, 5'h12);
    ev(6'h15, 5'h07);
    chk(D, 8'h31);
    chk(M, 8'h12);
    wb(1, D, 32'hff);
    wb(1, M, 32'hff);
    chk(D, 8'h31);
    chk(M, 8'h12);
    wb(1, ltsd_pkg::ADDR_CTRL, 32'h6);
    chk(M, 8'h00);
    ev(6'h28, 5'h09);
    chk(D, 8'h00);
    wb(1, ltsd_pkg::ADDR_CTRL, 32'h3);
    ev(6'h01, 5'h01);
    ev(6'h19, 5'h11);
    chk(D, 8'h19);
    chk(M, 8'h11);
    chk(ltsd_pkg::ADDR_CTRL, 8'h0b);
    close_out();
  end
endmodule
`default_nettype wire
